// [rtl/acqdma_defines.svh]
// register offsets, field positions, reset values and sizing constants
// assumes inclusion by the top module and the testbench only
`ifndef ACQDMA_DEFINES_SVH
`define ACQDMA_DEFINES_SVH
`define ACQ_OFF_CTRL   8'h00
`define ACQ_OFF_CAPLEN 8'h04
`define ACQ_OFF_DSEL   8'h08
`define ACQ_OFF_DSTART 8'h0C
`define ACQ_OFF_DLEN   8'h10
`define ACQ_OFF_DCTRL  8'h14
`define ACQ_OFF_DFIRST 8'h18
`define ACQ_OFF_STATUS 8'h1C
`define ACQ_OFF_TSTAMP 8'h20
`define ACQ_OFF_WRADDR 8'h24
`define ACQ_CTRL_ACQ   0
`define ACQ_CTRL_TEST  1
`define ACQ_CTRL_DUAL  2
`define ACQ_CTRL_SNAP  3
`define ACQ_CTRL_ROLE  5:4
`define ACQ_CTRL_GO    6
`define ACQ_DC_NEXT    2:0
`define ACQ_DC_LAST    3
`define ACQ_DC_GATE    4
`define ACQ_DC_META    5
`define ACQ_CTRL_RST   32'h0000_0000
`define ACQ_CAPLEN_RST 32'h0000_0400
`define ACQ_BANK_MB    512
`define ACQ_SAMP_BYTES 2
`define ACQ_STEP_1CH   32'h0000_0004
`define ACQ_STEP_2CH   32'h0000_0002
`endif

// [rtl/acqdma_pkg.sv]
// types shared by the acquisition and transfer engine
// assumes the defines header sits beside it in rtl/
`default_nettype none
package acqdma_pkg;
  typedef logic [11:0] acqdma_samp_t;
  typedef struct packed {
    acqdma_samp_t ch2;
    acqdma_samp_t ch1;
  } acqdma_pair_t;
  typedef struct packed {
    logic [15:0] b3;
    logic [15:0] b2;
    logic [15:0] b1;
    logic [15:0] b0;
  } acqdma_quad_t;
  typedef struct packed {
    logic        meta;
    logic [63:0] data;
  } acqdma_pkt_t;
  typedef struct packed {
    logic [31:0] start;
    logic [31:0] len;
    logic [5:0]  ctl;
  } acqdma_desc_t;
  typedef enum logic [1:0] {
    ROLE_GATE = 2'h0,
    ROLE_PPS  = 2'h1,
    ROLE_SYNC = 2'h2
  } acqdma_role_t;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_LOAD = 3'h1,
    D_RUN  = 3'h3,
    D_META = 3'h2,
    D_NEXT = 3'h6
  } acqdma_dstate_t;
endpackage
`default_nettype wire

// [rtl/acqdma_top.sv]
// sample capture into four banks and linked-list transfer to the host
// assumes APB master, bank memory controller and host stream sink outside
//
// Functional notes
// - samples come from the converter or an internal test ramp.
// - banks act as a streaming FIFO or hold one transient snapshot.
// - single-channel mode spreads the one input over all four banks.
// - dual-channel: channel one to banks 1,2; channel two to 3,4.
// - capture runs every cycle at full rate, twelve-bit samples, no gaps.
// - engine walks a linked descriptor list moving bank data to host.
// - gate-driven link length equals the data captured while gate high.
// - optional metadata word per transfer: time stamp and length.
// - sample clock at half rate; samples from both edges are used.
// - timing input acts as gate, pulse-per-second or sync.
// - sync bus gives gate, reset, reference clock; reference clock out.
// - each of four banks spans 512 megabytes.
//
// The APB register port and the address map were chosen for this implementation.
`default_nettype none
`include "acqdma_defines.svh"

module acqdma_fifo #(
  parameter int W     = 65,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  // depth must be a power of two so pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] rp;
  logic [AW-1:0] wp;
  logic [AW:0]   count;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rp    <= '0;
      wp    <= '0;
      count <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      unique case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule // acqdma_fifo

module acqdma_top
  import acqdma_pkg::*;
#(
  parameter int DESC_N     = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int BANK_AW    =
    $clog2(`ACQ_BANK_MB * 1024 * 1024 / `ACQ_SAMP_BYTES)
) (
  input  wire logic                CLOCK,
  input  wire logic                RST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic [31:0]              PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire acqdma_pkg::acqdma_pair_t ADC_RISE,
  input  wire acqdma_pkg::acqdma_pair_t ADC_FALL,
  input  wire logic                TTL_IN,
  input  wire logic                SYNC_GATE_IN,
  input  wire logic                SYNC_RESET_IN,
  input  wire logic                SYNC_REFCLK_IN,
  output logic                     REF_CLK_OUT,
  output logic [3:0]               BANK_WR_EN,
  output logic [BANK_AW-1:0]       BANK_WR_ADDR,
  output acqdma_pkg::acqdma_quad_t BANK_WR_DATA,
  output logic                     BANK_RD_EN,
  output logic [BANK_AW-1:0]       BANK_RD_ADDR,
  input  wire acqdma_pkg::acqdma_quad_t BANK_RD_DATA,
  input  wire logic                BANK_RD_VALID,
  output acqdma_pkg::acqdma_pkt_t  HOST_TX,
  output logic                     HOST_TX_VALID,
  input  wire logic                HOST_TX_READY
);
  import acqdma_pkg::*;
  localparam int DI = $clog2(DESC_N);

  // control registers
  logic           acq_en;
  logic           src_test;
  logic           dual;
  logic           snap;
  acqdma_role_t   role;
  logic           go;
  logic [31:0]    caplen;
  logic [DI-1:0]  dsel;
  logic [DI-1:0]  dfirst;
  logic [31:0]    dstart;
  logic [31:0]    dlen;
  acqdma_desc_t   desc_mem [DESC_N];

  // acquisition state
  logic [11:0]         ramp;
  logic [BANK_AW-1:0]  wr_addr;
  logic [31:0]         cap_cnt;
  logic                cap_done;
  logic [31:0]         gate_len;
  logic [31:0]         tstamp;
  logic                gate_prev;
  logic                ttl_prev;
  wire                 acq_gate;

  // transfer engine state
  acqdma_dstate_t      state;
  acqdma_dstate_t      next_state;
  logic [DI-1:0]       cur;
  acqdma_desc_t        dsc;
  logic [BANK_AW-1:0]  rd_addr;
  logic [31:0]         xfer;
  logic                pend;
  logic [31:0]         ts_start;
  logic [31:0]         rdata;
  logic                rerr;

  // apb decode
  wire setup   = PSEL & ~PENABLE;
  wire wr_acc  = PSEL & PENABLE & PWRITE;
  wire h_ctrl  = PADDR == `ACQ_OFF_CTRL;
  wire h_cap   = PADDR == `ACQ_OFF_CAPLEN;
  wire h_dsel  = PADDR == `ACQ_OFF_DSEL;
  wire h_dst   = PADDR == `ACQ_OFF_DSTART;
  wire h_dlen  = PADDR == `ACQ_OFF_DLEN;
  wire h_dctl  = PADDR == `ACQ_OFF_DCTRL;
  wire h_dfst  = PADDR == `ACQ_OFF_DFIRST;
  wire h_stat  = PADDR == `ACQ_OFF_STATUS;
  wire h_ts    = PADDR == `ACQ_OFF_TSTAMP;
  wire h_wra   = PADDR == `ACQ_OFF_WRADDR;
  wire h_any   = h_ctrl | h_cap | h_dsel | h_dst | h_dlen | h_dctl |
                 h_dfst | h_stat | h_ts | h_wra;
  wire busy    = state != D_IDLE;
  wire [31:0] ctrl_rd = {26'h0, role, snap, dual, src_test, acq_en};
  wire [31:0] stat_rd = {24'h0, 5'(cur), cap_done, acq_gate, busy};
  wire [31:0] rd_mux =
    h_ctrl ? ctrl_rd :
    h_cap  ? caplen :
    h_dsel ? 32'(dsel) :
    h_dst  ? dstart :
    h_dlen ? dlen :
    h_dfst ? 32'(dfirst) :
    h_stat ? stat_rd :
    h_ts   ? tstamp :
    h_wra  ? 32'(wr_addr) : 32'h0000_0000;
  assign PREADY  = 1'b1;
  assign PRDATA  = rdata;
  assign PSLVERR = rerr;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata <= 32'h0000_0000;
      rerr  <= 1'b0;
    end else if (setup) begin
      rdata <= rd_mux;
      rerr  <= ~h_any;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      {acq_en, src_test, dual, snap} <= 4'(`ACQ_CTRL_RST);
      role   <= ROLE_GATE;
      go     <= 1'b0;
      caplen <= `ACQ_CAPLEN_RST;
      dsel   <= '0;
      dfirst <= '0;
      dstart <= 32'h0000_0000;
      dlen   <= 32'h0000_0000;
    end else begin
      go <= wr_acc & h_ctrl & PWDATA[`ACQ_CTRL_GO];
      if (wr_acc & h_ctrl) begin
        acq_en   <= PWDATA[`ACQ_CTRL_ACQ];
        src_test <= PWDATA[`ACQ_CTRL_TEST];
        dual     <= PWDATA[`ACQ_CTRL_DUAL];
        snap     <= PWDATA[`ACQ_CTRL_SNAP];
        role     <= acqdma_role_t'(PWDATA[`ACQ_CTRL_ROLE]);
      end
      if (wr_acc & h_cap) caplen <= PWDATA;
      if (wr_acc & h_dsel) dsel <= PWDATA[DI-1:0];
      if (wr_acc & h_dfst) dfirst <= PWDATA[DI-1:0];
      if (wr_acc & h_dst) dstart <= PWDATA;
      if (wr_acc & h_dlen) dlen <= PWDATA;
    end
  end

  // descriptor table, committed by the control-word write
  always_ff @(posedge CLOCK) begin
    if (wr_acc & h_dctl) begin
      desc_mem[dsel] <= '{dstart, dlen, PWDATA[5:0]};
    end
  end

  // timing input roles and sync bus
  assign acq_gate = (role == ROLE_GATE) ? TTL_IN : SYNC_GATE_IN;
  wire gate_rise = acq_gate & ~gate_prev;
  wire ttl_rise  = TTL_IN & ~ttl_prev;
  wire pps_rise  = (role == ROLE_PPS) & ttl_rise;
  wire sync_rise = (role == ROLE_SYNC) & ttl_rise;
  wire ts_clear  = pps_rise | sync_rise | SYNC_RESET_IN;
  wire [31:0] ts_step = dual ? `ACQ_STEP_2CH : `ACQ_STEP_1CH;

  // source selection and bank steering
  wire acqdma_quad_t test_q = '{{4'h0, ramp + 12'h003},
                                {4'h0, ramp + 12'h002},
                                {4'h0, ramp + 12'h001},
                                {4'h0, ramp}};
  // both edge samples of the half-rate clock fill one bank word
  wire acqdma_quad_t one_q  = '{{4'h0, ADC_FALL.ch2}, {4'h0, ADC_FALL.ch1},
                                {4'h0, ADC_RISE.ch2},
                                {4'h0, ADC_RISE.ch1}};
  wire acqdma_quad_t two_q  = '{{4'h0, ADC_FALL.ch2}, {4'h0, ADC_RISE.ch2},
                                {4'h0, ADC_FALL.ch1},
                                {4'h0, ADC_RISE.ch1}};
  wire acqdma_quad_t src_q  = src_test ? test_q :
                              dual ? two_q : one_q;
  wire wr_fire = acq_en & acq_gate & ~(snap & cap_done);
  wire cap_last = snap & wr_fire & (cap_cnt + 32'h1 == caplen);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BANK_WR_EN   <= 4'h0;
      BANK_WR_ADDR <= '0;
      BANK_WR_DATA <= '0;
      REF_CLK_OUT  <= 1'b0;
      gate_prev    <= 1'b0;
      ttl_prev     <= 1'b0;
    end else begin
      BANK_WR_EN  <= {4{wr_fire}};
      REF_CLK_OUT <= SYNC_REFCLK_IN;
      gate_prev   <= acq_gate;
      ttl_prev    <= TTL_IN;
      if (wr_fire) begin
        BANK_WR_ADDR <= wr_addr;
        BANK_WR_DATA <= src_q;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ramp     <= 12'h000;
      wr_addr  <= '0;
      cap_cnt  <= 32'h0000_0000;
      cap_done <= 1'b0;
      gate_len <= 32'h0000_0000;
      tstamp   <= 32'h0000_0000;
    end else begin
      tstamp <= ts_clear ? 32'h0000_0000 : tstamp + ts_step;
      if (wr_fire) ramp <= ramp + 12'h004;
      if (!acq_en) begin
        wr_addr  <= '0;
        cap_cnt  <= 32'h0000_0000;
        cap_done <= 1'b0;
      end else if (wr_fire) begin
        // address wraps at bank capacity in streaming use
        wr_addr <= wr_addr + 1'b1;
        cap_cnt <= cap_cnt + 32'h1;
        if (cap_last) cap_done <= 1'b1;
      end
      if (gate_rise) gate_len <= {31'h0, wr_fire};
      else if (wr_fire) gate_len <= gate_len + 32'h1;
    end
  end

  // transfer engine
  wire acqdma_desc_t ld = desc_mem[cur];
  wire d_gate  = dsc.ctl[`ACQ_DC_GATE];
  wire fifo_in_ready;
  wire avail   = d_gate ? (xfer < gate_len) : (xfer < dsc.len);
  wire done    = d_gate ? (~acq_gate & ~pend & (xfer == gate_len))
                        : (~pend & (xfer == dsc.len));
  wire issue   = (state == D_RUN) & avail & ~pend & fifo_in_ready;
  wire load_ok = ~ld.ctl[`ACQ_DC_GATE] | gate_rise;
  wire acqdma_pkt_t fifo_in = (state == D_META) ?
       acqdma_pkt_t'{1'b1, {ts_start, xfer}} :
       acqdma_pkt_t'{1'b0, BANK_RD_DATA};
  wire fifo_in_valid = (pend & BANK_RD_VALID) | (state == D_META);
  assign BANK_RD_EN   = issue;
  assign BANK_RD_ADDR = rd_addr;

  always_comb begin
    next_state = state;
    unique case (state)
      D_IDLE: if (go) next_state = D_LOAD;
      D_LOAD: if (load_ok) next_state = D_RUN;
      D_RUN:  if (done) begin
        next_state = dsc.ctl[`ACQ_DC_META] ? D_META : D_NEXT;
      end
      D_META: if (fifo_in_ready) next_state = D_NEXT;
      D_NEXT: next_state = dsc.ctl[`ACQ_DC_LAST] ? D_IDLE : D_LOAD;
      default: next_state = D_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= D_IDLE;
      cur      <= '0;
      dsc      <= '0;
      rd_addr  <= '0;
      xfer     <= 32'h0000_0000;
      pend     <= 1'b0;
      ts_start <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == D_IDLE && go) cur <= dfirst;
      if (state == D_NEXT) cur <= dsc.ctl[DI-1:0];
      if (state == D_LOAD && load_ok) begin
        dsc      <= ld;
        xfer     <= 32'h0000_0000;
        ts_start <= tstamp;
        rd_addr  <= ld.ctl[`ACQ_DC_GATE] ? wr_addr
                                         : ld.start[BANK_AW-1:0];
      end
      if (issue) begin
        pend    <= 1'b1;
        rd_addr <= rd_addr + 1'b1;
        xfer    <= xfer + 32'h1;
      end else if (BANK_RD_VALID) begin
        pend <= 1'b0;
      end
    end
  end

  // reads are issued only with room, so returned words are never dropped
  acqdma_fifo #(
    .W     ($bits(acqdma_pkt_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (HOST_TX_VALID),
    .out_ready (HOST_TX_READY),
    .out_data  (HOST_TX)
  );

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_single_bank_map:
    assert property (wr_fire && !src_test && !dual |=>
      BANK_WR_DATA.b1 == {4'h0, $past(ADC_RISE.ch2)} &&
      BANK_WR_DATA.b2 == {4'h0, $past(ADC_FALL.ch1)})
    else $error("single-channel bank steering wrong");
  a_dual_bank_map:
    assert property (wr_fire && !src_test && dual |=>
      BANK_WR_DATA.b1 == {4'h0, $past(ADC_FALL.ch1)} &&
      BANK_WR_DATA.b2 == {4'h0, $past(ADC_RISE.ch2)})
    else $error("dual-channel bank steering wrong");
  a_test_ramp_step:
    assert property (wr_fire && src_test ##1 wr_fire && src_test |=>
      BANK_WR_DATA.b0[11:0] == $past(BANK_WR_DATA.b0[11:0]) + 12'h004)
    else $error("test ramp did not advance by four");
  a_gapless_write:
    assert property (acq_en && acq_gate && !snap |=> BANK_WR_EN == 4'hF)
    else $error("capture skipped a cycle");
  a_gapless_addr:
    assert property (BANK_WR_EN[0] ##1 BANK_WR_EN[0] |->
      BANK_WR_ADDR == $past(BANK_WR_ADDR) + 1'b1)
    else $error("bank address not consecutive");
  a_snap_stops:
    assert property (cap_last && acq_en |=> !wr_fire [*2])
    else $error("snapshot kept writing after its length");
  a_fixed_len:
    assert property (state == D_RUN && next_state != D_RUN && !d_gate |->
      xfer == dsc.len && !pend)
    else $error("fixed link closed at wrong length");
  a_gate_close:
    assert property (state == D_RUN && d_gate && next_state != D_RUN |->
      !acq_gate && xfer == gate_len ##1 xfer == $past(gate_len))
    else $error("gated link closed early or late");
  a_meta_length:
    assert property ($rose(state == D_META) |->
      fifo_in.meta && fifo_in.data[31:0] == (d_gate ? gate_len : dsc.len))
    else $error("metadata length does not match transfer");
endmodule // acqdma_top
`default_nettype wire

// [tb/acqdma_host_model.sv]
// host stream sink and bank memory model beside the capture block
// assumes one clock; stall is commanded by the bench
`default_nettype none
module acqdma_host_model (
  input  wire logic                     CLOCK,
  input  wire logic                     stall,
  input  wire logic [3:0]               wr_en,
  input  wire logic [27:0]              wr_addr,
  input  wire acqdma_pkg::acqdma_quad_t wr_data,
  input  wire logic                     rd_en,
  input  wire logic [27:0]              rd_addr,
  output acqdma_pkg::acqdma_quad_t      rd_data,
  output logic                          rd_valid,
  output logic                          tx_ready
);
  import acqdma_pkg::*;
  acqdma_quad_t mem [logic [27:0]];
  logic [27:0]  pa;
  logic         pend = 1'b0;
  int           wn;
  initial begin
    rd_data = '0;
    rd_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // idle data bus toggles, so a stale word never passes as fresh
  always @(posedge CLOCK) begin
    if (wr_en[0])
      mem[wr_addr] = wr_data;
    tx_ready <= !stall && ($urandom_range(3) != 0);
    rd_valid <= 1'b0;
    rd_data <= ~rd_data;
    if (rd_en) begin
      pend = 1'b1;
      pa = rd_addr;
      wn = $urandom_range(2);
    end else if (pend && wn > 0) begin
      wn--;
    end else if (pend) begin
      pend = 1'b0;
      rd_valid <= 1'b1;
      rd_data <= mem.exists(pa) ? mem[pa] : {4{pa[15:0]}};
    end
  end
endmodule // acqdma_host_model
`default_nettype wire

// [tb/testbench.sv]
// bench: capture paths, roles, snapshot, linked and gated transfers
// assumes the host and bank model is compiled first
`default_nettype none
`include "acqdma_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import acqdma_pkg::*;
  logic         CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]   PADDR = '0;
  logic [31:0]  PWDATA = '0, PRDATA;
  logic         PREADY, PSLVERR, REF_CLK_OUT, BANK_RD_EN, BANK_RD_VALID;
  logic         HOST_TX_VALID, HOST_TX_READY, TTL_IN = 0, SYNC_GATE_IN = 0;
  logic         SYNC_RESET_IN = 0, SYNC_REFCLK_IN = 0;
  acqdma_pair_t ADC_RISE = '0, ADC_FALL = '0;
  logic [3:0]   BANK_WR_EN;
  logic [27:0]  BANK_WR_ADDR, BANK_RD_ADDR, la;
  acqdma_quad_t BANK_WR_DATA, BANK_RD_DATA, lq, rq;
  acqdma_pkt_t  HOST_TX;
  logic         stall = 1, tst = 0, seq = 0, rst_q = 0;
  logic [11:0]  r;
  logic [65:0]  an, apq [$];
  logic [128:0] hn, hq [$];
  acqdma_quad_t wq [$];
  int           n_errors = 0, tests_run = 0, n_wr = 0, n_rd = 0, c0;
  acqdma_top u_dut (
    .CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .ADC_RISE, .ADC_FALL, .TTL_IN, .SYNC_GATE_IN,
    .SYNC_RESET_IN, .SYNC_REFCLK_IN, .REF_CLK_OUT, .BANK_WR_EN,
    .BANK_WR_ADDR, .BANK_WR_DATA, .BANK_RD_EN, .BANK_RD_ADDR,
    .BANK_RD_DATA, .BANK_RD_VALID, .HOST_TX, .HOST_TX_VALID, .HOST_TX_READY
  );
  acqdma_host_model u_host (
    .CLOCK, .stall, .wr_en(BANK_WR_EN), .wr_addr(BANK_WR_ADDR),
    .wr_data(BANK_WR_DATA), .rd_en(BANK_RD_EN), .rd_addr(BANK_RD_ADDR),
    .rd_data(BANK_RD_DATA), .rd_valid(BANK_RD_VALID),
    .tx_ready(HOST_TX_READY)
  );
  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) SYNC_REFCLK_IN <= ~SYNC_REFCLK_IN;
  always @(posedge CLOCK) rst_q <= RST_N;
  task automatic check(string nm, logic [71:0] e, logic [71:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic acqdma_quad_t q_of(acqdma_pair_t a, acqdma_pair_t b,
                                        logic dual);
    if (dual)
      return {4'h0, b.ch2, 4'h0, a.ch2, 4'h0, b.ch1, 4'h0, a.ch1};
    return {4'h0, b.ch2, 4'h0, b.ch1, 4'h0, a.ch2, 4'h0, a.ch1};
  endfunction
  // request held until pready is seen high; one idle cycle after
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [65:0] n);
    int k;
    apq.push_back(n);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 64);
    if (k >= 64) check("pready", 1, 0);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 64'h0});
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] d,
                    logic e = 1'b0);
    apb(1'b0, a, '0, {1'b1, e, m, d});
  endtask
  task automatic desc(logic [31:0] i, logic [31:0] s, logic [31:0] n,
                      logic [31:0] c);
    wr(`ACQ_OFF_DSEL, i);
    wr(`ACQ_OFF_DSTART, s);
    wr(`ACQ_OFF_DLEN, n);
    wr(`ACQ_OFF_DCTRL, c);
  endtask
  task automatic note_host(logic m, logic [63:0] d, logic [63:0] k = '1);
    hq.push_back({k, m, d & k});
  endtask
  // note the pair sampled at this edge, then present a fresh one
  task automatic capture(logic dual, int n);
    repeat (n) begin
      wq.push_back(q_of(ADC_RISE, ADC_FALL, dual));
      ADC_RISE <= 24'($urandom());
      ADC_FALL <= 24'($urandom());
      @(posedge CLOCK);
    end
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (hq.size() > 0 && k < 600) begin
      @(posedge CLOCK);
      k++;
    end
    if (k >= 600) begin
      check("host_drain", 0, hq.size());
      print_verdict();
    end
  endtask
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && apq.size() > 0) begin
      an = apq.pop_front();
      check("pslverr", an[64], PSLVERR);
      if (an[65]) check("prdata", an[31:0], PRDATA & an[63:32]);
    end
    if (HOST_TX_VALID === 1'b1 && HOST_TX_READY) begin
      hn = hq.size() > 0 ? hq.pop_front() : '1;
      check("host_pkt", hn[64:0],
            {HOST_TX.meta, HOST_TX.data & hn[128:65]});
    end
  end
  always @(negedge CLOCK) begin
    if (rst_q) check("refclk", !SYNC_REFCLK_IN, REF_CLK_OUT);
    if (BANK_RD_EN === 1'b1) n_rd++;
    if (BANK_WR_EN !== 4'h0) begin
      n_wr++;
      check("wr_en", 4'hF, BANK_WR_EN);
      if (seq) check("wr_addr", la + 28'h1, BANK_WR_ADDR);
      r = lq.b0[11:0] + 12'h4;
      rq = {4'h0, r + 12'h3, 4'h0, r + 12'h2, 4'h0, r + 12'h1, 4'h0, r};
      if (tst && seq)
        check("ramp", rq, BANK_WR_DATA);
      else if (wq.size() > 0)
        check("wr_data", wq.pop_front(), BANK_WR_DATA);
      lq = BANK_WR_DATA;
      la = BANK_WR_ADDR;
    end
    seq = (BANK_WR_EN !== 4'h0);
  end
  initial begin
    repeat (30000) @(posedge CLOCK);
    check("timeout", 0, 1);
    print_verdict();
  end
  initial begin
    void'($urandom(32'h5ABC));
    repeat (20) @(posedge CLOCK);
    check("rst_pready", 1, PREADY);
    check("rst_txv", 0, HOST_TX_VALID);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    rd(`ACQ_OFF_CTRL, '1, `ACQ_CTRL_RST);
    rd(`ACQ_OFF_CAPLEN, '1, `ACQ_CAPLEN_RST);
    rd(8'h28, '1, 32'h0, 1'b1);
    TTL_IN <= 1'b1;
    wr(`ACQ_OFF_CTRL, 32'h1);
    repeat (3) @(posedge CLOCK);
    capture(1'b0, 24);
    wr(`ACQ_OFF_CTRL, 32'h5);
    repeat (3) @(posedge CLOCK);
    capture(1'b1, 24);
    wr(`ACQ_OFF_CTRL, 32'h3);
    repeat (3) @(posedge CLOCK);
    tst = 1'b1;
    repeat (12) @(posedge CLOCK);
    tst = 1'b0;
    wr(`ACQ_OFF_CTRL, 32'h0);
    wr(`ACQ_OFF_CAPLEN, 32'h5);
    c0 = n_wr;
    wr(`ACQ_OFF_CTRL, 32'h9);
    repeat (20) @(posedge CLOCK);
    check("snap_len", 5, n_wr - c0);
    rd(`ACQ_OFF_STATUS, 32'h4, 32'h4);
    for (int i = 0; i < 4; i++) begin
      SYNC_GATE_IN <= (i == 3);
      wr(`ACQ_OFF_CTRL, {26'h0, (i == 3) ? 2'h2 : 2'(i), 4'h1});
      repeat (3) @(posedge CLOCK);
      c0 = n_wr;
      repeat (10) @(posedge CLOCK);
      check("role_wr", (i == 0 || i == 3) ? 10 : 0, n_wr - c0);
    end
    wr(`ACQ_OFF_CTRL, 32'h0);
    SYNC_GATE_IN <= 1'b0;
    desc(0, 32'h100, 3, 32'h01);
    desc(1, 32'h200, 9, 32'h28);
    wr(`ACQ_OFF_DFIRST, 32'h0);
    for (int a = 0; a < 12; a++) begin
      c0 = (a < 3) ? 32'h100 + a : 32'h1FD + a;
      note_host(1'b0, {4{c0[15:0]}});
    end
    note_host(1'b1, 64'd9, 64'hFFFF_FFFF);
    n_rd = 0;
    wr(`ACQ_OFF_CTRL, 32'h40);
    repeat (60) @(posedge CLOCK);
    check("fifo_fill", 8, n_rd);
    stall <= 1'b0;
    drain();
    stall <= 1'b1;
    TTL_IN <= 1'b0;
    ADC_RISE <= 24'($urandom());
    ADC_FALL <= 24'($urandom());
    desc(2, 32'h0, 32'h0, 32'h38);
    wr(`ACQ_OFF_DFIRST, 32'h2);
    wr(`ACQ_OFF_CTRL, 32'h41);
    repeat (4) @(posedge CLOCK);
    c0 = n_wr;
    TTL_IN <= 1'b1;
    repeat (6) @(posedge CLOCK);
    TTL_IN <= 1'b0;
    repeat (8) @(posedge CLOCK);
    c0 = n_wr - c0;
    check("gate_wr", 6, c0);
    repeat (c0) note_host(1'b0, q_of(ADC_RISE, ADC_FALL, 1'b0));
    note_host(1'b1, 64'(c0), 64'hFFFF_FFFF);
    stall <= 1'b0;
    drain();
    rd(`ACQ_OFF_STATUS, 32'h1, 32'h0);
    SYNC_RESET_IN <= 1'b1;
    @(posedge CLOCK);
    SYNC_RESET_IN <= 1'b0;
    @(posedge CLOCK);
    rd(`ACQ_OFF_TSTAMP, '1, `ACQ_STEP_1CH);
    check("wq_left", 0, wq.size());
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
